// >>> src/vlms_consts.svh
`ifndef VLMS_CONSTS_SVH
`define VLMS_CONSTS_SVH

// command codes of the four registers
`define VLMS_CMD_UPPER      8'h24
`define VLMS_CMD_MHIGH      8'h25
`define VLMS_CMD_MLOW       8'h26
`define VLMS_CMD_RATE       8'h27

// slew rate word layout
`define VLMS_RATE_EXP_HI    15
`define VLMS_RATE_EXP_LO    11
`define VLMS_RATE_MAN_HI    10
`define VLMS_RATE_EXP_RST   5'h1C
`define VLMS_RATE_MAN_RST   11'h010

// reset values of the limit and margin words
`define VLMS_UPPER_RST      16'h1000
`define VLMS_MARGIN_RST     16'h0000

// margin field of the operation command
`define VLMS_MARGIN_LOW     2'h1
`define VLMS_MARGIN_HIGH    2'h2

// valid command plus trim range per loop scale, in mV
`define VLMS_RANGE_S1_MV    32'd700
`define VLMS_RANGE_S05_MV   32'd1400
`define VLMS_RANGE_S025_MV  32'd2800
`define VLMS_RANGE_S0125_MV 32'd6000
`define VLMS_MV_PER_V       32'd1000

// accepted slew rate, in thousandths of a mV/us
`define VLMS_RATE_MIN_UMV   50'd67
`define VLMS_RATE_MAX_UMV   50'd15933
`define VLMS_RATE_Q_ONE     50'd4096
`define VLMS_FRAC_BITS      12

// slew update tick
`define VLMS_CLK_NS         8
`define VLMS_TICK_NS        1000
`define VLMS_TICK_CYCLES    (`VLMS_TICK_NS / `VLMS_CLK_NS)

`endif

// >>> src/vlms_pkg.sv
package vlms_pkg;

	typedef struct packed {
		logic [15:0] upper;
		logic [15:0] mhigh;
		logic [15:0] mlow;
		logic [15:0] rate;
		logic [15:0] target;
		logic [15:0] rd_data;
		logic        rd_valid;
		logic        eval;
		logic        warn_evt;
		logic        inval_evt;
		logic        warn;
		logic        inval;
		logic        tick;
		logic [11:0] tick_cnt;
		logic [1:0]  last_margin;
	} vlms_regs_state_t;

	typedef struct packed {
		logic [27:0] acc;
	} vlms_slew_state_t;

endpackage

// >>> src/vlms_regs.sv
// What this block does
// - Out-of-range trim write is refused and flagged as invalid data.
// - Trim beyond a limit clamps reference to limit, warns while converting.
// - Valid target range is 0.7, 1.4, 2.8 or 6.0 V per loop scale.
// - Upper limit is 16-bit unsigned absolute, caps every target.
// - Target above upper limit while converting clamps, warns, alerts.
// - Lowering upper limit below target gives the same clamp and warning.
// - Margin high selects margin-high value plus trim.
// - Margin low selects margin-low value plus trim.
// - Margin entry and exit move at the programmed slew rate.
// - Margin writes breaking the upper limit are refused as invalid.
// - Slew rate register sets mV/us rate of all normal changes.
// - On and off ramps ignore the programmed slew rate.
// - Slew word: 5-bit exponent resetting to -4, 11-bit mantissa.
// - Slew rates outside 0.067 to 15.933 mV/us are refused.
// - Target below lower limit clamps up with the same warning.
`timescale 1ns/1ps
`include "vlms_consts.svh"

module vlms_regs
	import vlms_pkg::*;
#(
	parameter int TICK_CYCLES = `VLMS_TICK_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        wr_en,
	input  wire logic [7:0]  wr_cmd,
	input  wire logic [15:0] wr_data,
	input  wire logic        rd_en,
	input  wire logic [7:0]  rd_cmd,
	output logic      [15:0] rd_data,
	output logic             rd_valid,
	input  wire logic [15:0] vout_command,
	input  wire logic        cmd_wr,
	input  wire logic [15:0] trim_value,
	input  wire logic        trim_wr,
	input  wire logic [15:0] trim_wr_data,
	output logic             trim_accept,
	input  wire logic [15:0] vout_min,
	input  wire logic        mode_relative,
	input  wire logic [4:0]  mode_exp,
	input  wire logic [1:0]  scale_sel,
	input  wire logic [1:0]  margin_sel,
	input  wire logic        conv_en,
	input  wire logic        on_off_ramp,
	input  wire logic        clear_status,
	output logic      [15:0] target_code,
	output logic      [15:0] ref_code,
	output logic             ref_settled,
	output logic             status_limit_warn,
	output logic             status_invalid_data,
	output logic             alert
);

	if (TICK_CYCLES < 2 || TICK_CYCLES > 4096) begin : g_chk
		$error("TICK_CYCLES must lie in 2..4096");
	end

	localparam vlms_regs_state_t ST_RST = '{
		upper:   `VLMS_UPPER_RST,
		mhigh:   `VLMS_MARGIN_RST,
		mlow:    `VLMS_MARGIN_RST,
		rate:    {`VLMS_RATE_EXP_RST, `VLMS_RATE_MAN_RST},
		default: '0
	};

	// decoded slew rate in mV/us times 4096; zero for non-positive mantissa
	function automatic logic [39:0] vlms_rate_q(input logic [15:0] r);
		logic signed [5:0] sh;
		logic        [39:0] m;
		sh = $signed({r[`VLMS_RATE_EXP_HI], r[15:11]}) + 6'sd12;
		m = {29'h0, r[`VLMS_RATE_MAN_HI:0]};
		if (r[`VLMS_RATE_MAN_HI] || r[`VLMS_RATE_MAN_HI:0] == 11'h000) begin
			return 40'h0;
		end
		if (sh >= 0) begin
			return m << sh;
		end
		return m >> (-sh);
	endfunction

	function automatic logic vlms_rate_ok(input logic [15:0] r);
		logic [49:0] q;
		q = {10'h000, vlms_rate_q(r)} * 50'd1000;
		return q >= `VLMS_RATE_MIN_UMV * `VLMS_RATE_Q_ONE &&
			q <= `VLMS_RATE_MAX_UMV * `VLMS_RATE_Q_ONE;
	endfunction

	// base target before trim for a margin selection
	function automatic logic signed [17:0] vlms_base(
		input logic [1:0]  sel,
		input logic        rel,
		input logic [15:0] cmd,
		input logic [15:0] mh,
		input logic [15:0] ml
	);
		logic signed [17:0] c;
		c = $signed({2'b00, cmd});
		case (sel)
			`VLMS_MARGIN_HIGH: begin
				return rel ? c + $signed({2'b00, mh}) : $signed({2'b00, mh});
			end
			`VLMS_MARGIN_LOW: begin
				return rel ? c - $signed({2'b00, ml}) : $signed({2'b00, ml});
			end
			default: begin
				return c;
			end
		endcase
	endfunction

	vlms_regs_state_t   st;
	vlms_regs_state_t   next_s;
	logic        [3:0]  lsb_shift;
	logic        [4:0]  neg_exp;
	logic        [31:0] range_mv;
	logic        [31:0] range_full;
	logic        [15:0] range_code;
	logic signed [17:0] trim_s;
	logic signed [17:0] range_s;
	logic signed [17:0] upper_s;
	logic signed [17:0] min_s;
	logic signed [17:0] req_s;
	logic signed [17:0] trim_cand;
	logic signed [17:0] mh_cand;
	logic signed [17:0] ml_cand;
	logic signed [17:0] lim_s;
	logic               trim_ok;
	logic               upper_ok;
	logic               mh_ok;
	logic               ml_ok;
	logic               req_above;
	logic               req_below;
	logic        [39:0] step_full;
	logic        [27:0] step_q;

	assign neg_exp   = 5'h00 - mode_exp;
	assign lsb_shift = neg_exp[3:0];

	// valid range as an output code at the present exponent
	always_comb begin
		case (scale_sel)
			2'h0: range_mv = `VLMS_RANGE_S1_MV;
			2'h1: range_mv = `VLMS_RANGE_S05_MV;
			2'h2: range_mv = `VLMS_RANGE_S025_MV;
			default: range_mv = `VLMS_RANGE_S0125_MV;
		endcase
		range_full = (range_mv << lsb_shift) / `VLMS_MV_PER_V;
		range_code = (range_full > 32'h0000FFFF) ? 16'hFFFF :
			range_full[15:0];
	end

	assign trim_s  = $signed({{2{trim_value[15]}}, trim_value});
	assign range_s = $signed({2'b00, range_code});
	assign upper_s = $signed({2'b00, st.upper});
	assign min_s   = $signed({2'b00, vout_min});
	assign req_s   = vlms_base(margin_sel, mode_relative, vout_command,
		st.mhigh, st.mlow) + trim_s;

	// candidate target with the new trim
	assign trim_cand = vlms_base(margin_sel, mode_relative, vout_command,
		st.mhigh, st.mlow) + $signed({{2{trim_wr_data[15]}}, trim_wr_data});
	assign trim_ok   = trim_cand >= 0 && trim_cand <= range_s;
	// the limit itself must fit the range
	assign upper_ok  = wr_data <= range_code;
	// margin plus trim must respect limit and range
	assign mh_cand   = vlms_base(`VLMS_MARGIN_HIGH, mode_relative,
		vout_command, wr_data, st.mlow) + trim_s;
	assign ml_cand   = vlms_base(`VLMS_MARGIN_LOW, mode_relative,
		vout_command, st.mhigh, wr_data) + trim_s;
	assign mh_ok     = mh_cand >= 0 && mh_cand <= upper_s && mh_cand <= range_s;
	assign ml_ok     = ml_cand >= 0 && ml_cand <= upper_s && ml_cand <= range_s;

	// limit violations of the requested target
	assign req_above = req_s > upper_s;
	assign req_below = req_s < min_s;

	// slew step in output codes per tick, 12 fraction bits
	always_comb begin
		step_full = (vlms_rate_q(st.rate) << lsb_shift) / 40'd1000;
		step_q = (step_full == 40'h0) ? 28'h0000001 : step_full[27:0];
	end

	always_comb begin
		next_s = st;
		lim_s = req_s;
		next_s.rd_valid  = 1'b0;
		next_s.eval      = 1'b0;
		next_s.warn_evt  = 1'b0;
		next_s.inval_evt = 1'b0;
		next_s.tick      = 1'b0;
		if (st.tick_cnt == 12'(TICK_CYCLES - 1)) begin
			next_s.tick_cnt = 12'h000;
			next_s.tick = 1'b1;
		end else begin
			next_s.tick_cnt = st.tick_cnt + 12'h001;
		end
		if (rd_en) begin
			next_s.rd_valid = 1'b1;
			case (rd_cmd)
				`VLMS_CMD_UPPER: next_s.rd_data = st.upper;
				`VLMS_CMD_MHIGH: next_s.rd_data = st.mhigh;
				`VLMS_CMD_MLOW:  next_s.rd_data = st.mlow;
				`VLMS_CMD_RATE:  next_s.rd_data = st.rate;
				default:         next_s.rd_data = 16'h0000;
			endcase
		end
		if (wr_en) begin
			case (wr_cmd)
				// a new limit re-checks the present target
				`VLMS_CMD_UPPER: begin
					if (upper_ok) begin
						next_s.upper = wr_data;
						next_s.eval = 1'b1;
					end else begin
						next_s.inval_evt = 1'b1;
					end
				end
				`VLMS_CMD_MHIGH: begin
					if (mh_ok) begin
						next_s.mhigh = wr_data;
						next_s.eval = 1'b1;
					end else begin
						next_s.inval_evt = 1'b1;
					end
				end
				`VLMS_CMD_MLOW: begin
					if (ml_ok) begin
						next_s.mlow = wr_data;
						next_s.eval = 1'b1;
					end else begin
						next_s.inval_evt = 1'b1;
					end
				end
				// whole word stored only when accepted
				`VLMS_CMD_RATE: begin
					if (vlms_rate_ok(wr_data)) begin
						next_s.rate = wr_data;
					end else begin
						next_s.inval_evt = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
		if (trim_wr) begin
			if (trim_ok) begin
				next_s.eval = 1'b1;
			end else begin
				next_s.inval_evt = 1'b1;
			end
		end
		// margin entry or exit re-targets through the slewer
		if (cmd_wr || margin_sel != st.last_margin) begin
			next_s.eval = 1'b1;
		end
		next_s.last_margin = margin_sel;
		// clamp to limit, warn while converting
		if (req_above) begin
			lim_s = upper_s;
		end else if (req_below) begin
			lim_s = min_s;
		end
		if (st.eval && conv_en && (req_above || req_below)) begin
			next_s.warn_evt = 1'b1;
		end
		// dac ceiling clamps silently
		if (lim_s > range_s) begin
			lim_s = range_s;
		end
		if (lim_s < 0) begin
			lim_s = 18'sd0;
		end
		next_s.target = lim_s[15:0];
		// sticky status, a new event beats the clear
		if (clear_status) begin
			next_s.warn = 1'b0;
			next_s.inval = 1'b0;
		end
		if (next_s.warn_evt) begin
			next_s.warn = 1'b1;
		end
		if (next_s.inval_evt) begin
			next_s.inval = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st <= ST_RST;
		end else begin
			st <= next_s;
		end
	end

	vlms_slew u_slew (
		.clk      (clk),
		.rst      (rst),
		.tick     (st.tick),
		.bypass   (on_off_ramp || !conv_en),
		.step_q   (step_q),
		.target   (st.target),
		.ref_code (ref_code),
		.settled  (ref_settled)
	);

	assign rd_data             = st.rd_data;
	assign rd_valid            = st.rd_valid;
	assign trim_accept         = trim_wr && trim_ok;
	assign target_code         = st.target;
	assign status_limit_warn   = st.warn;
	assign status_invalid_data = st.inval;
	assign alert               = st.warn || st.inval;

	a_rate_reject: assert property (@(posedge clk) disable iff (rst)
		wr_en && wr_cmd == `VLMS_CMD_RATE && !vlms_rate_ok(wr_data)
		|=> st.rate == $past(st.rate) && status_invalid_data)
		else $error("bad slew rate was stored or not flagged");

	a_upper_reject: assert property (@(posedge clk) disable iff (rst)
		wr_en && wr_cmd == `VLMS_CMD_UPPER && !upper_ok
		|=> $stable(st.upper) && status_invalid_data)
		else $error("bad upper limit was stored or not flagged");

	a_trim_invalid: assert property (@(posedge clk) disable iff (rst)
		trim_wr && !trim_ok |-> !trim_accept ##1 status_invalid_data)
		else $error("bad trim not refused");

	a_margin_reject: assert property (@(posedge clk) disable iff (rst)
		wr_en && wr_cmd == `VLMS_CMD_MHIGH && !mh_ok
		|=> $stable(st.mhigh) && alert)
		else $error("bad margin high was stored or not flagged");

	a_warn_clamp: assert property (@(posedge clk) disable iff (rst)
		st.eval && conv_en && req_above
		|=> status_limit_warn &&
		target_code == $past(upper_s > range_s ? range_code : st.upper))
		else $error("target above limit not clamped or warned");

	a_low_warn: assert property (@(posedge clk) disable iff (rst)
		st.eval && conv_en && req_below && !req_above
		|=> st.warn_evt && status_limit_warn)
		else $error("target below lower limit not warned");

	a_set_wins: assert property (@(posedge clk) disable iff (rst)
		next_s.warn_evt && clear_status |=> status_limit_warn)
		else $error("clear beat a simultaneous warning");

endmodule

// >>> src/vlms_slew.sv
`timescale 1ns/1ps
`include "vlms_consts.svh"

module vlms_slew
	import vlms_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        tick,
	input  wire logic        bypass,
	input  wire logic [27:0] step_q,
	input  wire logic [15:0] target,
	output logic      [15:0] ref_code,
	output logic             settled
);

	vlms_slew_state_t st;
	vlms_slew_state_t next_s;
	logic [27:0]      tgt_q;
	logic [27:0]      diff;

	assign tgt_q = {target, 12'h000};

	always_comb begin
		next_s = st;
		diff = 28'h0000000;
		if (bypass) begin
			next_s.acc = tgt_q;
		end else if (tick) begin
			if (st.acc < tgt_q) begin
				diff = tgt_q - st.acc;
				next_s.acc = (diff <= step_q) ? tgt_q : st.acc + step_q;
			end else if (st.acc > tgt_q) begin
				diff = st.acc - tgt_q;
				next_s.acc = (diff <= step_q) ? tgt_q : st.acc - step_q;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_s;
		end
	end

	assign ref_code = st.acc[27:`VLMS_FRAC_BITS];
	assign settled  = (st.acc == tgt_q);

	a_bypass_jump: assert property (@(posedge clk) disable iff (rst)
		bypass |=> ref_code == $past(target))
		else $error("reference did not jump during on/off ramp");

	a_hold_between: assert property (@(posedge clk) disable iff (rst)
		!bypass && !tick |=> $stable(st.acc))
		else $error("reference moved between ticks");

	a_step_size: assert property (@(posedge clk) disable iff (rst)
		!bypass && tick && tgt_q > st.acc && tgt_q - st.acc > step_q
		|=> st.acc == $past(st.acc) + $past(step_q))
		else $error("reference step differs from slew step");

	a_no_overshoot: assert property (@(posedge clk) disable iff (rst)
		!bypass && tick && st.acc > tgt_q
		|=> st.acc >= $past(tgt_q) && st.acc < $past(st.acc))
		else $error("reference overshot target going down");

endmodule

// >>> tb/vlms_host.sv
`timescale 1ns/1ps

module vlms_host (
	input  wire logic        clk,
	output logic             wr_en,
	output logic      [7:0]  wr_cmd,
	output logic      [15:0] wr_data,
	output logic             rd_en,
	output logic      [7:0]  rd_cmd,
	input  wire logic [15:0] rd_data,
	input  wire logic        rd_valid
);
	initial begin
		wr_en = 1'b0;
		wr_cmd = 8'h00;
		wr_data = 16'h0000;
		rd_en = 1'b0;
		rd_cmd = 8'h00;
	end

	task automatic write_word(input logic [7:0] c, input logic [15:0] d);
		@(posedge clk);
		wr_en <= 1'b1;
		wr_cmd <= c;
		wr_data <= d;
		@(posedge clk);
		wr_en <= 1'b0;
		// released lines do not keep the last word
		wr_cmd <= ~c;
		wr_data <= ~d;
	endtask

	task automatic read_word(input logic [7:0] c, output logic [15:0] d,
			output logic ok);
		@(posedge clk);
		rd_en <= 1'b1;
		rd_cmd <= c;
		@(posedge clk);
		rd_en <= 1'b0;
		rd_cmd <= ~c;
		@(posedge clk);
		ok = rd_valid;
		d = rd_data;
	endtask
endmodule

// >>> tb/vout_limit_margin_slew_regs_test.sv
`timescale 1ns/1ps
`include "vlms_consts.svh"

module vout_limit_margin_slew_regs_test;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [15:0] vout_command = 16'h0100;
	logic [15:0] trim_value = 16'h0000;
	logic [15:0] trim_wr_data = 16'h0000;
	logic [15:0] vout_min = 16'h0040;
	logic        cmd_wr = 1'b0;
	logic        trim_wr = 1'b0;
	logic        mode_relative = 1'b0;
	logic        conv_en = 1'b1;
	logic        on_off_ramp = 1'b1;
	logic        clear_status = 1'b0;
	logic [4:0]  mode_exp = 5'h18;
	logic [1:0]  scale_sel = 2'h3;
	logic [1:0]  margin_sel = 2'h0;
	logic        wr_en, rd_en, rd_valid, trim_accept, ref_settled;
	logic        status_limit_warn, status_invalid_data, alert;
	logic [7:0]  wr_cmd, rd_cmd;
	logic [15:0] wr_data, rd_data, target_code, ref_code, rv;
	logic        ok;
	int          failures = 0;
	int          tests_run = 0;
	int          cycles = 0;
	int          t0;
	logic [15:0] rate_d [5] = '{16'hE002, 16'hE001, 16'hE0FF, 16'hE800,
		16'hE0FE};
	logic [15:0] rate_rb [5] = '{16'hE002, 16'hE002, 16'hE002, 16'hE002,
		16'hE0FE};
	logic        rate_bad [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};

	vlms_host host (.clk(clk), .wr_en(wr_en), .wr_cmd(wr_cmd),
		.wr_data(wr_data), .rd_en(rd_en), .rd_cmd(rd_cmd),
		.rd_data(rd_data), .rd_valid(rd_valid));

	vlms_regs #(.TICK_CYCLES(4)) dut (.clk(clk), .rst(rst), .wr_en(wr_en),
		.wr_cmd(wr_cmd), .wr_data(wr_data), .rd_en(rd_en), .rd_cmd(rd_cmd),
		.rd_data(rd_data), .rd_valid(rd_valid), .vout_command(vout_command),
		.cmd_wr(cmd_wr), .trim_value(trim_value), .trim_wr(trim_wr),
		.trim_wr_data(trim_wr_data), .trim_accept(trim_accept),
		.vout_min(vout_min), .mode_relative(mode_relative),
		.mode_exp(mode_exp), .scale_sel(scale_sel), .margin_sel(margin_sel),
		.conv_en(conv_en), .on_off_ramp(on_off_ramp),
		.clear_status(clear_status), .target_code(target_code),
		.ref_code(ref_code), .ref_settled(ref_settled),
		.status_limit_warn(status_limit_warn),
		.status_invalid_data(status_invalid_data), .alert(alert));

	always #4 clk = ~clk;

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			failures++;
			$display("mismatch timeout expected done seen hang");
			tally_and_finish();
		end
	end

	task automatic check(input string n, input logic [15:0] seen,
			input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", n, exp, seen);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic clr;
		@(posedge clk);
		clear_status <= 1'b1;
		@(posedge clk);
		clear_status <= 1'b0;
		cyc(1);
	endtask

	task automatic rd(input logic [7:0] c, input logic [15:0] exp);
		host.read_word(c, rv, ok);
		check("rd_valid", {15'h0, ok}, 16'h0001);
		check("rd_data", rv, exp);
	endtask

	task automatic flags(input logic w, input logic inv);
		check("warn", {15'h0, status_limit_warn}, {15'h0, w});
		check("invalid", {15'h0, status_invalid_data}, {15'h0, inv});
		check("alert", {15'h0, alert}, {15'h0, w | inv});
	endtask

	task automatic wr_chk(input logic [7:0] c, input logic [15:0] d,
			input logic bad, input logic [15:0] rb);
		host.write_word(c, d);
		cyc(2);
		flags(1'b0, bad);
		clr();
		rd(c, rb);
	endtask

	task automatic trim(input logic [15:0] d, input logic acc);
		@(posedge clk);
		trim_wr <= 1'b1;
		trim_wr_data <= d;
		#1;
		check("trim_accept", {15'h0, trim_accept}, {15'h0, acc});
		@(posedge clk);
		trim_wr <= 1'b0;
		if (acc)
			trim_value <= d;
		cyc(3);
	endtask

	task automatic wait_ref(input logic [15:0] exp);
		int i;
		i = 0;
		while (ref_settled !== 1'b1 && i < 3000) begin
			cyc(1);
			i++;
		end
		check("ref_code", ref_code, exp);
	endtask

	initial begin
		cyc(10);
		rst <= 1'b0;
		@(posedge clk);
		cmd_wr <= 1'b1;
		@(posedge clk);
		cmd_wr <= 1'b0;
		cyc(3);
		check("ref_code", ref_code, 16'h0100);
		rd(`VLMS_CMD_UPPER, 16'h1000);
		rd(`VLMS_CMD_MHIGH, 16'h0000);
		rd(`VLMS_CMD_MLOW, 16'h0000);
		rd(`VLMS_CMD_RATE, 16'hE010);
		rd(8'h28, 16'h0000);
		flags(1'b0, 1'b0);
		$display("test reset values done");
		for (int k = 0; k < 5; k++)
			wr_chk(`VLMS_CMD_RATE, rate_d[k], rate_bad[k], rate_rb[k]);
		wr_chk(`VLMS_CMD_UPPER, 16'h0700, 1'b1, 16'h1000);
		wr_chk(`VLMS_CMD_UPPER, 16'h0600, 1'b0, 16'h0600);
		wr_chk(`VLMS_CMD_MHIGH, 16'h0700, 1'b1, 16'h0000);
		wr_chk(`VLMS_CMD_MHIGH, 16'h0200, 1'b0, 16'h0200);
		wr_chk(`VLMS_CMD_MLOW, 16'h0080, 1'b0, 16'h0080);
		wr_chk(`VLMS_CMD_MLOW, 16'h0601, 1'b1, 16'h0080);
		$display("test register writes done");
		@(posedge clk);
		on_off_ramp <= 1'b0;
		margin_sel <= `VLMS_MARGIN_HIGH;
		t0 = cycles;
		cyc(3);
		check("target", target_code, 16'h0200);
		check("settled", {15'h0, ref_settled}, 16'h0000);
		wait_ref(16'h0200);
		// 256 codes at 4.064 codes per 4-cycle tick
		check("slew_time", {15'h0, (cycles - t0) inside {[240:270]}},
			16'h0001);
		@(posedge clk);
		margin_sel <= `VLMS_MARGIN_LOW;
		cyc(3);
		check("target", target_code, 16'h0080);
		wait_ref(16'h0080);
		@(posedge clk);
		margin_sel <= 2'h0;
		cyc(3);
		wait_ref(16'h0100);
		flags(1'b0, 1'b0);
		$display("test margin slew done");
		host.write_word(`VLMS_CMD_UPPER, 16'h00C0);
		cyc(2);
		check("target", target_code, 16'h00C0);
		flags(1'b1, 1'b0);
		wait_ref(16'h00C0);
		clr();
		trim(16'h0040, 1'b1);
		check("target", target_code, 16'h00C0);
		flags(1'b1, 1'b0);
		clr();
		trim(16'h0600, 1'b0);
		flags(1'b0, 1'b1);
		clr();
		trim(16'hFF00, 1'b1);
		check("target", target_code, 16'h0040);
		flags(1'b1, 1'b0);
		wait_ref(16'h0040);
		clr();
		$display("test limits and trim done");
		@(posedge clk);
		on_off_ramp <= 1'b1;
		trim(16'h0000, 1'b1);
		check("ref_code", ref_code, 16'h00C0);
		$display("test ramp bypass done");
		clr();
		// a warning and a clear in the same cycle
		@(posedge clk);
		trim_wr <= 1'b1;
		trim_wr_data <= 16'h0040;
		@(posedge clk);
		trim_wr <= 1'b0;
		trim_value <= 16'h0040;
		clear_status <= 1'b1;
		@(posedge clk);
		clear_status <= 1'b0;
		cyc(1);
		flags(1'b1, 1'b0);
		clr();
		@(posedge clk);
		conv_en <= 1'b0;
		trim(16'h0000, 1'b1);
		flags(1'b0, 1'b0);
		check("ref_code", ref_code, 16'h00C0);
		@(posedge clk);
		conv_en <= 1'b1;
		host.write_word(`VLMS_CMD_UPPER, 16'h0600);
		@(posedge clk);
		mode_relative <= 1'b1;
		margin_sel <= `VLMS_MARGIN_HIGH;
		cyc(3);
		check("target", target_code, 16'h0300);
		@(posedge clk);
		margin_sel <= `VLMS_MARGIN_LOW;
		cyc(3);
		check("target", target_code, 16'h0080);
		$display("test status and relative margin done");
		tally_and_finish();
	end
endmodule
